// File: ccx_exec.sv
// module: apb-driven executor for call, branch, clear, complement and inc/dec instructions
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/100ps
module ccx_exec
   import ccx_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   logic [12:0] pc_ff, nxt_pc;
   logic [12:0] stack_ff, nxt_stack;
   logic [7:0] page_ff, nxt_page;
   logic [7:0] w_ff, nxt_w;
   logic zero_ff, nxt_zero;
   logic timeout_ff, nxt_timeout;
   logic pdown_ff, nxt_pdown;
   logic skip_ff, nxt_skip;
   logic wait_ff, nxt_wait;
   logic [7:0] wdt_ff, nxt_wdt;
   logic [7:0] presc_ff, nxt_presc;
   logic [6:0] faddr_ff, nxt_faddr;
   logic [31:0] prdata_ff, nxt_prdata;
   logic [7:0] file_mem [0:127];

   ccx_dec_t dec;
   logic [13:0] opcode;
   logic access, hit_instr, two_cycle, exec;
   logic mapped, wr_page, wr_w, wr_status, wr_faddr, wr_fdata;
   logic [7:0] operand, alu_result;
   logic alu_zero;
   logic alu_op, file_wr;
   logic [7:0] file_wdata;
   logic [6:0] file_waddr;

   assign opcode = pwdata[13:0];
   assign access = psel & penable;
   assign hit_instr = access & pwrite & (paddr == CCX_OFF_INSTR);

   // decode: casez on patterns ignores operand and don't-care bits
   always_comb begin
      dec.dest = opcode[7]; // RL8
      dec.faddr = opcode[6:0];
      dec.imm = opcode[10:0];
      casez (opcode) // RL14
         CCX_PAT_CALL: dec.op = CCX_CALL_OP;
         CCX_PAT_BRANCH: dec.op = CCX_BRANCH_OP;
         CCX_PAT_CLRF: dec.op = CCX_CLEAR_FILE_OP;
         CCX_PAT_CLRW: dec.op = CCX_CLEAR_W_OP; // RL5
         CCX_PAT_WDTCLR: dec.op = CCX_WATCHDOG_CLEAR_OP;
         CCX_PAT_COMPLEMENT_FILE_OP: dec.op = CCX_COMPLEMENT_FILE_OP;
         CCX_PAT_DECREMENT_FILE_OP: dec.op = CCX_DECREMENT_FILE_OP;
         CCX_PAT_DECREMENT_SKIP_ZERO_OP: dec.op = CCX_DECREMENT_SKIP_ZERO_OP;
         CCX_PAT_INCREMENT_FILE_OP: dec.op = CCX_INCREMENT_FILE_OP;
         CCX_PAT_INCREMENT_SKIP_ZERO_OP: dec.op = CCX_INCREMENT_SKIP_ZERO_OP;
         // opcodes outside this subset retire here as plain pc+1
         default: dec.op = CCX_NO_OPERATION;
      endcase
      // the already fetched instruction after a taken skip is discarded
      if (skip_ff) begin
         dec.op = CCX_NO_OPERATION; // RL10 RL11 RL12
      end
   end

   assign two_cycle = (dec.op == CCX_CALL_OP) | (dec.op == CCX_BRANCH_OP); // RL1 RL3
   // two-cycle ops hold the bus one extra access cycle
   assign pready = ~(hit_instr & two_cycle & ~wait_ff); // RL1 RL3
   assign exec = hit_instr & pready;

   assign operand = file_mem[dec.faddr];
   ccx_alu u_alu (
      .op(dec.op),
      .operand(operand),
      .result(alu_result),
      .zero(alu_zero)
   );
   assign alu_op = (dec.op == CCX_COMPLEMENT_FILE_OP) | (dec.op == CCX_DECREMENT_FILE_OP)
      | (dec.op == CCX_DECREMENT_SKIP_ZERO_OP) | (dec.op == CCX_INCREMENT_FILE_OP)
      | (dec.op == CCX_INCREMENT_SKIP_ZERO_OP);

   assign mapped = (paddr == CCX_OFF_INSTR) | (paddr == CCX_OFF_PAGE) | (paddr == CCX_OFF_WREG)
      | (paddr == CCX_OFF_STATUS) | (paddr == CCX_OFF_PC) | (paddr == CCX_OFF_STACK)
      | (paddr == CCX_OFF_WDT) | (paddr == CCX_OFF_FADDR) | (paddr == CCX_OFF_FDATA);
   assign pslverr = access & ~mapped;
   assign wr_page = access & pwrite & (paddr == CCX_OFF_PAGE);
   assign wr_w = access & pwrite & (paddr == CCX_OFF_WREG);
   assign wr_status = access & pwrite & (paddr == CCX_OFF_STATUS);
   assign wr_faddr = access & pwrite & (paddr == CCX_OFF_FADDR);
   assign wr_fdata = access & pwrite & (paddr == CCX_OFF_FDATA);

   // file register write port
   always_comb begin
      file_wr = 1'b0;
      file_waddr = faddr_ff;
      file_wdata = pwdata[7:0];
      if (wr_fdata) begin
         file_wr = 1'b1;
      end else if (exec && dec.op == CCX_CLEAR_FILE_OP) begin
         file_wr = 1'b1; // RL4
         file_waddr = dec.faddr;
         file_wdata = CCX_BYTE_RST;
      end else if (exec && alu_op && dec.dest) begin
         file_wr = 1'b1; // RL8
         file_waddr = dec.faddr;
         file_wdata = alu_result;
      end
   end

   // memory is data, not control, so it carries no reset
   always_ff @(posedge pclk) begin
      if (file_wr) begin
         file_mem[file_waddr] <= file_wdata;
      end
   end

   // cpu state next values
   always_comb begin
      nxt_pc = pc_ff;
      nxt_stack = stack_ff;
      nxt_page = page_ff;
      nxt_w = w_ff;
      nxt_zero = zero_ff;
      nxt_timeout = timeout_ff;
      nxt_pdown = pdown_ff;
      nxt_skip = skip_ff;
      nxt_wait = hit_instr & two_cycle & ~wait_ff;
      nxt_faddr = faddr_ff;
      nxt_presc = presc_ff + CCX_BYTE_ONE;
      nxt_wdt = (presc_ff == CCX_BYTE_MAX) ? wdt_ff + CCX_BYTE_ONE : wdt_ff;
      if (wr_page) begin
         nxt_page = pwdata[7:0];
      end
      if (wr_w) begin
         nxt_w = pwdata[7:0];
      end
      if (wr_faddr) begin
         nxt_faddr = pwdata[6:0];
      end
      if (wr_status) begin
         // zero is written; timeout and power-down are write-one-to-clear
         nxt_zero = pwdata[CCX_ST_ZERO];
         nxt_timeout = timeout_ff & ~pwdata[CCX_ST_TIMEOUT];
         nxt_pdown = pdown_ff & ~pwdata[CCX_ST_PDOWN];
      end
      if (exec) begin
         nxt_pc = pc_ff + 13'h0001;
         nxt_skip = 1'b0; // RL11
         case (dec.op)
            CCX_CALL_OP: begin
               nxt_stack = pc_ff + 13'h0001; // RL1
               nxt_pc = {page_ff[CCX_PAGE_HI:CCX_PAGE_LO], dec.imm}; // RL2
            end
            CCX_BRANCH_OP: begin
               nxt_pc = {page_ff[CCX_PAGE_HI:CCX_PAGE_LO], dec.imm}; // RL3
            end
            CCX_CLEAR_FILE_OP: begin
               nxt_zero = 1'b1; // RL4
            end
            CCX_CLEAR_W_OP: begin
               nxt_w = CCX_BYTE_RST; // RL5
               nxt_zero = 1'b1; // RL5
            end
            CCX_WATCHDOG_CLEAR_OP: begin
               nxt_wdt = CCX_WDT_CLR; // RL6
               nxt_presc = CCX_WDT_CLR; // RL6
               nxt_timeout = 1'b1; // RL6
               nxt_pdown = 1'b1; // RL6
            end
            CCX_COMPLEMENT_FILE_OP, CCX_DECREMENT_FILE_OP, CCX_INCREMENT_FILE_OP: begin
               nxt_zero = alu_zero; // RL7 RL9
               if (!dec.dest) begin
                  nxt_w = alu_result; // RL8
               end
            end
            CCX_DECREMENT_SKIP_ZERO_OP, CCX_INCREMENT_SKIP_ZERO_OP: begin
               nxt_skip = alu_zero; // RL10 RL12
               if (!dec.dest) begin
                  nxt_w = alu_result; // RL8
               end
            end
            default: begin
               nxt_pc = pc_ff + 13'h0001;
            end
         endcase
      end
   end

   // read data is captured in the setup cycle so prdata comes from a flop
   always_comb begin
      nxt_prdata = prdata_ff;
      if (psel && !penable && !pwrite) begin
         nxt_prdata = 32'h00000000;
         case (paddr)
            CCX_OFF_PAGE: nxt_prdata[7:0] = page_ff;
            CCX_OFF_WREG: nxt_prdata[7:0] = w_ff;
            CCX_OFF_STATUS: begin
               nxt_prdata[CCX_ST_ZERO] = zero_ff;
               nxt_prdata[CCX_ST_TIMEOUT] = timeout_ff;
               nxt_prdata[CCX_ST_PDOWN] = pdown_ff;
               nxt_prdata[CCX_ST_SKIP] = skip_ff;
            end
            CCX_OFF_PC: nxt_prdata[12:0] = pc_ff;
            CCX_OFF_STACK: nxt_prdata[12:0] = stack_ff;
            CCX_OFF_WDT: nxt_prdata[15:0] = {presc_ff, wdt_ff};
            CCX_OFF_FADDR: nxt_prdata[6:0] = faddr_ff;
            CCX_OFF_FDATA: nxt_prdata[7:0] = file_mem[faddr_ff];
            default: nxt_prdata = 32'h00000000;
         endcase
      end
   end
   assign prdata = prdata_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_ff <= CCX_PC_RST;
         stack_ff <= CCX_PC_RST;
         page_ff <= CCX_BYTE_RST;
         w_ff <= CCX_BYTE_RST;
         zero_ff <= 1'b0;
         timeout_ff <= CCX_TIMEOUT_RST;
         pdown_ff <= CCX_PDOWN_RST;
         skip_ff <= 1'b0;
         wait_ff <= 1'b0;
         wdt_ff <= CCX_WDT_CLR;
         presc_ff <= CCX_WDT_CLR;
         faddr_ff <= 7'h00;
         prdata_ff <= 32'h00000000;
      end else begin
         pc_ff <= nxt_pc;
         stack_ff <= nxt_stack;
         page_ff <= nxt_page;
         w_ff <= nxt_w;
         zero_ff <= nxt_zero;
         timeout_ff <= nxt_timeout;
         pdown_ff <= nxt_pdown;
         skip_ff <= nxt_skip;
         wait_ff <= nxt_wait;
         wdt_ff <= nxt_wdt;
         presc_ff <= nxt_presc;
         faddr_ff <= nxt_faddr;
         prdata_ff <= nxt_prdata;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic is_call, is_branch, is_skipop;
   logic [6:0] dec_faddr;
   logic [10:0] dec_imm;
   logic [7:0] page_hi;
   assign is_call = exec & (dec.op == CCX_CALL_OP);
   assign is_branch = exec & (dec.op == CCX_BRANCH_OP);
   assign is_skipop = exec & ((dec.op == CCX_DECREMENT_SKIP_ZERO_OP)
      | (dec.op == CCX_INCREMENT_SKIP_ZERO_OP));
   assign dec_faddr = dec.faddr;
   assign dec_imm = dec.imm;
   assign page_hi = page_ff;

   property p_call_push;
      is_call |=> stack_ff == $past(pc_ff) + 13'h0001;
   endproperty
   a_call_push: assert property (p_call_push) else $error("call return address wrong"); // RL1

   property p_call_target;
      is_call |=> pc_ff == {$past(page_hi[4:3]), $past(dec_imm)};
   endproperty
   a_call_target: assert property (p_call_target) else $error("call target wrong"); // RL2

   property p_two_cycle;
      (hit_instr && two_cycle && !wait_ff) |-> !pready ##1 (wait_ff && pready);
   endproperty
   a_two_cycle: assert property (p_two_cycle) else $error("branch not two cycles"); // RL3

   property p_branch_target;
      is_branch |=> pc_ff == {$past(page_hi[4:3]), $past(dec_imm)} && stack_ff == $past(stack_ff);
   endproperty
   a_branch_target: assert property (p_branch_target) else $error("branch target wrong"); // RL3

   property p_clrf;
      (exec && dec.op == CCX_CLEAR_FILE_OP) |=> file_mem[$past(dec_faddr)] == 8'h00 && zero_ff;
   endproperty
   a_clrf: assert property (p_clrf) else $error("file clear failed"); // RL4

   property p_clrw;
      (exec && dec.op == CCX_CLEAR_W_OP) |=> w_ff == 8'h00 && zero_ff;
   endproperty
   a_clrw: assert property (p_clrw) else $error("w clear failed"); // RL5

   property p_wdt;
      (exec && dec.op == CCX_WATCHDOG_CLEAR_OP) |=> wdt_ff == 8'h00 && presc_ff == 8'h00
         && timeout_ff && pdown_ff;
   endproperty
   a_wdt: assert property (p_wdt) else $error("watchdog clear failed"); // RL6

   property p_complement_file_op_w;
      (exec && dec.op == CCX_COMPLEMENT_FILE_OP && !dec.dest) |=> w_ff == ~$past(operand);
   endproperty
   a_complement_file_op_w: assert property (p_complement_file_op_w) else $error("complement to w wrong"); // RL7 RL8

   property p_skip_flags;
      is_skipop |=> zero_ff == $past(zero_ff) && skip_ff == $past(alu_zero);
   endproperty
   a_skip_flags: assert property (p_skip_flags) else $error("skip op flag behaviour wrong"); // RL10 RL12

   property p_discard;
      (exec && skip_ff) |=> !skip_ff && w_ff == $past(w_ff) && pc_ff == $past(pc_ff) + 13'h0001;
   endproperty
   a_discard: assert property (p_discard) else $error("skipped instruction not discarded"); // RL11

   property p_wrap;
      (exec && dec.op == CCX_INCREMENT_FILE_OP && dec.dest && operand == 8'hFF)
         |=> file_mem[$past(dec_faddr)] == 8'h00 && zero_ff;
   endproperty
   a_wrap: assert property (p_wrap) else $error("increment did not wrap"); // RL13 RL9
endmodule

// File: ccx_pkg.sv
// package: constants, opcode patterns and types of the call/branch/clear/inc-dec executor
// What this block does
// [RL1] call pushes the following instruction's address and takes two cycles
// [RL2] call loads 11-bit immediate into pc low bits, page latch bits 4:3 above
// [RL3] branch loads immediate and page latch bits 4:3 into pc, two cycles
// [RL4] clear file register writes zero in one cycle and sets zero flag
// [RL5] clear working register writes zero, sets zero flag, low seven bits ignored
// [RL6] watchdog clear zeroes counter and prescaler, sets timeout and power-down flags
// [RL7] complement inverts the file register, updates zero, writes per destination bit
// [RL8] destination bit 0 writes working register, 1 writes the file register
// [RL9] increment and decrement add or subtract one, update only zero flag
// [RL10] decrement-skip leaves flags alone and discards next instruction on zero result
// [RL11] a taken skip runs a no-operation instead, making two cycles
// [RL12] increment-skip leaves flags alone and skips next instruction on zero result
// [RL13] increment and decrement wrap modulo 256
// [RL14] don't-care opcode bits are ignored; all variants decode alike
package ccx_pkg;
   localparam int unsigned CCX_PC_W = 13;
   localparam int unsigned CCX_IMM_W = 11;
   localparam int unsigned CCX_OPC_W = 14;
   localparam int unsigned CCX_FA_W = 7;
   localparam int unsigned CCX_ADDR_W = 12;

   // register byte offsets
   localparam logic [11:0] CCX_OFF_INSTR = 12'h000;
   localparam logic [11:0] CCX_OFF_PAGE = 12'h004;
   localparam logic [11:0] CCX_OFF_WREG = 12'h008;
   localparam logic [11:0] CCX_OFF_STATUS = 12'h00C;
   localparam logic [11:0] CCX_OFF_PC = 12'h010;
   localparam logic [11:0] CCX_OFF_STACK = 12'h014;
   localparam logic [11:0] CCX_OFF_WDT = 12'h018;
   localparam logic [11:0] CCX_OFF_FADDR = 12'h01C;
   localparam logic [11:0] CCX_OFF_FDATA = 12'h020;

   // status field positions
   localparam int unsigned CCX_ST_ZERO = 0;
   localparam int unsigned CCX_ST_TIMEOUT = 1;
   localparam int unsigned CCX_ST_PDOWN = 2;
   localparam int unsigned CCX_ST_SKIP = 3;
   // page latch bits copied into pc 12:11
   localparam int unsigned CCX_PAGE_LO = 3;
   localparam int unsigned CCX_PAGE_HI = 4;

   // reset values and byte constants
   localparam logic [12:0] CCX_PC_RST = 13'h0000;
   localparam logic [7:0] CCX_BYTE_RST = 8'h00;
   localparam logic CCX_TIMEOUT_RST = 1'b1;
   localparam logic CCX_PDOWN_RST = 1'b1;
   localparam logic [7:0] CCX_WDT_CLR = 8'h00;
   localparam logic [7:0] CCX_BYTE_ONE = 8'h01;
   localparam logic [7:0] CCX_BYTE_MAX = 8'hFF;

   // opcode patterns, ? marks operand and don't-care bits
   localparam logic [13:0] CCX_PAT_CALL = 14'b10_0???_????_????;
   localparam logic [13:0] CCX_PAT_BRANCH = 14'b10_1???_????_????;
   localparam logic [13:0] CCX_PAT_CLRF = 14'b00_0001_1???_????;
   localparam logic [13:0] CCX_PAT_CLRW = 14'b00_0001_0???_????;
   localparam logic [13:0] CCX_PAT_WDTCLR = 14'b00_0000_0110_0100;
   localparam logic [13:0] CCX_PAT_COMPLEMENT_FILE_OP = 14'b00_1001_????_????;
   localparam logic [13:0] CCX_PAT_DECREMENT_FILE_OP = 14'b00_0011_????_????;
   localparam logic [13:0] CCX_PAT_DECREMENT_SKIP_ZERO_OP = 14'b00_1011_????_????;
   localparam logic [13:0] CCX_PAT_INCREMENT_FILE_OP = 14'b00_1010_????_????;
   localparam logic [13:0] CCX_PAT_INCREMENT_SKIP_ZERO_OP = 14'b00_1111_????_????;

   typedef enum logic [3:0] {
      CCX_NO_OPERATION,
      CCX_CALL_OP,
      CCX_BRANCH_OP,
      CCX_CLEAR_FILE_OP,
      CCX_CLEAR_W_OP,
      CCX_WATCHDOG_CLEAR_OP,
      CCX_COMPLEMENT_FILE_OP,
      CCX_DECREMENT_FILE_OP,
      CCX_DECREMENT_SKIP_ZERO_OP,
      CCX_INCREMENT_FILE_OP,
      CCX_INCREMENT_SKIP_ZERO_OP
   } ccx_op_t;

   typedef struct packed {
      ccx_op_t op;
      logic dest;
      logic [6:0] faddr;
      logic [10:0] imm;
   } ccx_dec_t;
endpackage

// File: ccx_alu.sv
// module: byte arithmetic for complement, increment and decrement
`timescale 1ns/100ps
module ccx_alu
   import ccx_pkg::*;
(
   // operation and operand
   input wire ccx_op_t op,
   input wire logic [7:0] operand,
   // result
   output logic [7:0] result,
   output logic zero
);
   always_comb begin
      case (op)
         CCX_COMPLEMENT_FILE_OP: begin
            result = ~operand; // RL7
         end
         // eight-bit sums drop the carry, so 0xFF+1 is 0 and 0-1 is 0xFF
         CCX_INCREMENT_FILE_OP, CCX_INCREMENT_SKIP_ZERO_OP: begin
            result = operand + CCX_BYTE_ONE; // RL9 RL13
         end
         CCX_DECREMENT_FILE_OP, CCX_DECREMENT_SKIP_ZERO_OP: begin
            result = operand - CCX_BYTE_ONE; // RL9 RL13
         end
         default: begin
            result = CCX_BYTE_RST;
         end
      endcase
      zero = (result == CCX_BYTE_RST);
   end
endmodule

// File: ccx_exec_test.sv
// testbench: apb-driven executor against a behavioural instruction model
`timescale 1ns/100ps
module ccx_exec_test;
   import ccx_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   int err_total = 0;
   int n_checks = 0;
   int seed = 32'h9DEC969E;
   int m_pc = 0;
   int m_stack = 0;
   int m_page = 0;
   int m_w = 0;
   int m_faddr = 0;
   bit m_z = 1'b0;
   bit m_to = 1'b1;
   bit m_pd = 1'b1;
   bit m_skip = 1'b0;
   logic [7:0] fmem [128];
   logic [31:0] rd;
   logic er;
   int w;
   logic [31:0] rv;
   logic [6:0] fa;
   logic [7:0] fv;
   logic [13:0] op;
   int kind;

   always #2.5 pclk = ~pclk;

   ccx_exec i_ccx_exec (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr)
   );

   task automatic final_report();
      if (err_total == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      // an unknown on either side is a mismatch, never a match of two unknowns
      if (seen !== exp || $isunknown(seen) || $isunknown(exp)) begin
         err_total++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one transfer; an idle edge first so no signal is driven twice in a step
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] q, output logic e, output int ws);
      ws = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         ws++;
         @(posedge pclk);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      int ws;
      apb(1'b1, a, d, q, e, ws);
      case (a)
         CCX_OFF_PAGE: m_page = int'(d[7:0]);
         CCX_OFF_WREG: m_w = int'(d[7:0]);
         CCX_OFF_FADDR: m_faddr = int'(d[6:0]);
         CCX_OFF_FDATA: fmem[m_faddr] = d[7:0];
         CCX_OFF_STATUS: begin
            m_z = d[0];
            if (d[1]) m_to = 1'b0;
            if (d[2]) m_pd = 1'b0;
         end
         default: ;
      endcase
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] q;
      logic e;
      int ws;
      apb(1'b0, a, 32'h0000_0000, q, e, ws);
      check(q, exp);
   endtask

   // reference behaviour of one executed instruction word
   task automatic m_exec(input logic [13:0] o);
      logic [7:0] f;
      logic [7:0] r;
      bit wb;
      f = fmem[o[6:0]];
      r = f;
      wb = 1'b0;
      m_pc = (m_pc + 1) % 8192;
      if (m_skip) begin
         m_skip = 1'b0;
         return;
      end
      casez (o)
         14'b10_0???_????_????: begin
            m_stack = m_pc;
            m_pc = int'({m_page[4:3], o[10:0]});
         end
         14'b10_1???_????_????: m_pc = int'({m_page[4:3], o[10:0]});
         14'b00_0001_1???_????: begin
            r = 8'h00;
            wb = 1'b1;
            m_z = 1'b1;
         end
         14'b00_0001_0???_????: begin
            m_w = 0;
            m_z = 1'b1;
         end
         14'b00_0000_0110_0100: begin
            m_to = 1'b1;
            m_pd = 1'b1;
         end
         14'b00_1001_????_????: r = ~f;
         14'b00_0011_????_????, 14'b00_1011_????_????: r = f - 8'h01;
         14'b00_1010_????_????, 14'b00_1111_????_????: r = f + 8'h01;
         default: ;
      endcase
      if (o[13:8] inside {6'h09, 6'h03, 6'h0A}) begin
         wb = 1'b1;
         m_z = (r == 8'h00);
      end
      if (o[13:8] inside {6'h0B, 6'h0F}) begin
         wb = 1'b1;
         m_skip = (r == 8'h00);
      end
      if (wb && o[7]) fmem[o[6:0]] = r;
      if (wb && !o[7]) m_w = int'(r);
   endtask

   task automatic exec(input logic [13:0] o);
      logic [31:0] q;
      logic e;
      int ws;
      int expw;
      expw = (!m_skip && o[13:12] == 2'b10) ? 1 : 0;
      apb(1'b1, CCX_OFF_INSTR, {18'h00000, o}, q, e, ws);
      check(32'(ws), 32'(expw));
      m_exec(o);
   endtask

   task automatic chk_all();
      rd_chk(CCX_OFF_PC, 32'(m_pc));
      rd_chk(CCX_OFF_STACK, 32'(m_stack));
      rd_chk(CCX_OFF_WREG, 32'(m_w));
      rd_chk(CCX_OFF_STATUS, {28'h0, m_skip, m_pd, m_to, m_z});
      rd_chk(CCX_OFF_FDATA, {24'h0, fmem[m_faddr]});
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      err_total++;
      final_report();
   end

   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      // file memory has no reset, so give the checked word a value first
      wr(CCX_OFF_FDATA, 32'h5A);
      chk_all();
      for (int i = 0; i < 80; i++) begin
         rv = $random(seed);
         kind = int'(rv[31:28]) % 10;
         fa = rv[6:0];
         fv = (rv[9:8] == 2'd0) ? 8'h00 : (rv[9:8] == 2'd1) ? 8'h01 : rv[27:20];
         if (rv[9:8] == 2'd2) fv = 8'hFF;
         wr(CCX_OFF_PAGE, $random(seed));
         wr(CCX_OFF_WREG, $random(seed));
         wr(CCX_OFF_STATUS, $random(seed) & 32'h7);
         wr(CCX_OFF_FADDR, {25'h0, fa});
         wr(CCX_OFF_FDATA, {24'h0, fv});
         rv = $random(seed);
         case (kind)
            0: op = {3'b100, rv[10:0]};
            1: op = {3'b101, rv[10:0]};
            2: op = {7'b0000011, fa};
            3: op = {7'b0000010, rv[6:0]};
            4: op = 14'h0064;
            5: op = {6'h09, rv[7], fa};
            6: op = {6'h03, rv[7], fa};
            7: op = {6'h0B, rv[7], fa};
            8: op = {6'h0A, rv[7], fa};
            default: op = {6'h0F, rv[7], fa};
         endcase
         exec(op);
         chk_all();
      end
      // taken skips discard a following call and branch in one cycle
      // an unknown word first retires any skip the loop left pending
      exec(14'h0000);
      wr(CCX_OFF_FADDR, 32'h5);
      wr(CCX_OFF_FDATA, 32'h1);
      exec(14'h0B85);
      exec(14'h2123);
      chk_all();
      wr(CCX_OFF_FDATA, 32'hFF);
      exec(14'h0F05);
      exec(14'h2800);
      chk_all();
      // increment past 0xFF, then decrement below zero, both into the file
      wr(CCX_OFF_FDATA, 32'hFF);
      exec(14'h0A85);
      chk_all();
      exec(14'h0385);
      chk_all();
      // watchdog clear after the counter has advanced
      wr(CCX_OFF_STATUS, 32'h6);
      // a full prescaler turn guarantees the counter has moved
      repeat (300) @(posedge pclk);
      apb(1'b0, CCX_OFF_WDT, 32'h0, rd, er, w);
      check(32'(rd[7:0] != 8'h00), 32'h1);
      exec(14'h0064);
      apb(1'b0, CCX_OFF_WDT, 32'h0, rd, er, w);
      check(32'({rd[31:16], rd[7:0]}), 32'h0);
      check(32'(rd[15:8] < 8'h10), 32'h1);
      rd_chk(CCX_OFF_STATUS, {28'h0, m_skip, m_pd, m_to, m_z});
      // read-only and unmapped places
      wr(CCX_OFF_PC, 32'h1FFF);
      rd_chk(CCX_OFF_PC, 32'(m_pc));
      apb(1'b0, 12'h040, 32'h0, rd, er, w);
      check(rd, 32'h0);
      check({31'h0, er}, 32'h1);
      apb(1'b1, 12'h044, 32'hFFFF_FFFF, rd, er, w);
      check({31'h0, er}, 32'h1);
      final_report();
   end
endmodule
